// file: core/adcso_cfg.svh
`ifndef ADCSO_CFG_SVH
`define ADCSO_CFG_SVH
// Width of one conversion result
`define ADCSO_RES_BITS   12
// Configuration bits that follow the start bit
`define ADCSO_CFG_BITS   3
// Last configuration bit index counted from zero
`define ADCSO_CFG_LAST   2'h2
// Result words held between converter and shifter
`define ADCSO_FIFO_DEPTH 8
// Output slot of the last MSB-first bit
`define ADCSO_MSB_LAST   5'h0b
// First output slot after the LSB-first tail, zeros from here on
`define ADCSO_TAIL_END   5'h17
// Field positions inside the configuration shift register
`define ADCSO_SGL_POS    2
`define ADCSO_POL_POS    1
`define ADCSO_ORD_POS    0
`endif

// file: core/adcso_pkg.sv
`include "adcso_cfg.svh"
package adcso_pkg;
    // Serial sequencer states
    typedef enum logic [1:0] {
        ST_WAIT_START,
        ST_CONFIG,
        ST_NULL_WAIT,
        ST_SHIFT_OUT
    } adcso_state_type;
    // One conversion result word
    typedef logic [`ADCSO_RES_BITS-1:0] adcso_word_type;
endpackage : adcso_pkg

// file: core/adcso_top.sv
// What this block does
// - Order bit one: MSB first, then zeros
// - Order bit zero: MSB first, then LSB first
// - Result coded as unipolar straight binary only
// - Shared data wire: host first, device after
// - Device drives line low on fourth falling edge
// - Select high shuts down, ignores all activity
// - Bias off after conversion, clock shifts remainder
// - Auto shutdown each conversion, select still low
// - Clock and data ignored while select high
// - Launch on falling edge, sample on rising
// - Skip leading zeros, first one starts; ignore extras
// - Three config bits: mode, polarity, order
// - One null bit, then result; select resets
`timescale 1ns/10ps
`include "adcso_cfg.svh"

module adcso_fifo #(
    parameter int WIDTH = `ADCSO_RES_BITS,
    parameter int DEPTH = `ADCSO_FIFO_DEPTH
) (
    input  wire logic             sys_clk,   // System clock
    input  wire logic             rst_b,     // Async reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // Word to store
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    output logic      [WIDTH-1:0] out_data,  // Oldest word
    output logic                  out_valid, // Oldest word present
    input  wire logic             out_ready  // Consumer takes word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];        // Word storage
    logic [AW-1:0]    wr_ptr;             // Next write slot
    logic [AW-1:0]    rd_ptr;             // Next read slot
    logic [AW:0]      count;              // Words held
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_in_ready;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Pointer and fill level update; ready is registered so it leaves a flop
    always_comb begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
        next_in_ready = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            in_ready <= next_in_ready;
        end
    end

    // Storage needs no reset; only written words are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : adcso_fifo

module adcso_top (
    input  wire logic                    sys_clk,                       // 40 MHz clock
    input  wire logic                    rst_b,                         // Async reset
    input  wire logic                    select_and_powerdown_input_b,  // Select pin
    input  wire logic                    shift_clock,                   // Serial clock pin
    input  wire logic                    serial_data_in,                // Config data pin
    output logic                         serial_data_out,               // Result data
    output logic                         serial_data_out_en_b,          // Drive enable
    input  wire adcso_pkg::adcso_word_type result_data,                 // Converter word
    input  wire logic                    result_valid,                  // Word offered
    output logic                         result_ready,                  // FIFO has room
    output logic                         bias_enable,                   // Comparator power
    output logic                         single_or_differential_select, // Input mode
    output logic                         channel_polarity_select,       // Channel sign
    output logic                         byte_order_select              // Output order
);
    import adcso_pkg::*;

    logic            sel_s1, sel_s2;          // Select synchroniser
    logic            clk_s1, clk_s2, clk_s3;  // Shift clock synchroniser plus edge stage
    logic            din_s1, din_s2;          // Data synchroniser
    logic            active;                  // Select is low
    logic            rise;                    // Shift clock rising edge seen
    logic            fall;                    // Shift clock falling edge seen
    adcso_state_type state, next_state;       // Sequencer state
    logic [1:0]      cfg_cnt, next_cfg_cnt;   // Config bits taken so far
    logic [2:0]      cfg, next_cfg;           // Config shift register
    logic [4:0]      slot, next_slot;         // Output slot after null bit
    adcso_word_type  result, next_result;     // Word being shifted
    logic            next_dout;
    logic            next_oe_b;
    logic            next_bias;
    logic            fifo_pop;                // Take a word at hold time
    logic            fifo_valid;
    adcso_word_type  fifo_data;

    // Pins come from the host's domain, so two flops before use
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            sel_s1 <= select_and_powerdown_input_b;
            sel_s2 <= sel_s1;
            clk_s1 <= shift_clock;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            din_s1 <= serial_data_in;
            din_s2 <= din_s1;
        end
    end

    assign active = !sel_s2;
    assign rise   = clk_s2 && !clk_s3;
    assign fall   = !clk_s2 && clk_s3;

    // Result words wait here; the converter stalls on result_ready
    adcso_fifo #(
        .WIDTH (`ADCSO_RES_BITS),
        .DEPTH (`ADCSO_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_data   (result_data),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Sequencer: start hunt, config capture, null bit, result shifting
    always_comb begin
        next_state   = state;
        next_cfg_cnt = cfg_cnt;
        next_cfg     = cfg;
        next_slot    = slot;
        next_result  = result;
        next_dout    = serial_data_out;
        next_oe_b    = serial_data_out_en_b;
        next_bias    = bias_enable;
        fifo_pop     = 1'b0;
        if (!active) begin
            // Select high: state, counters, bias and data back to rest, line released; config bits held
            next_state   = ST_WAIT_START;
            next_cfg_cnt = 2'h0;
            next_slot    = 5'h00;
            next_dout    = 1'b0;
            next_oe_b    = 1'b1;
            next_bias    = 1'b0;
        end else begin
            unique case (state)
                ST_WAIT_START: begin
                    // Leading zeros skipped, first one is the start bit
                    if (rise && din_s2) begin
                        next_state   = ST_CONFIG;
                        next_cfg_cnt = 2'h0;
                        next_bias    = 1'b1;
                    end
                end
                ST_CONFIG: begin
                    // Mode, polarity, order shifted in on rising edges
                    if (rise) begin
                        next_cfg     = {cfg[1:0], din_s2};
                        next_cfg_cnt = 2'(cfg_cnt + 1'b1);
                        if (cfg_cnt == `ADCSO_CFG_LAST) begin
                            next_state = ST_NULL_WAIT;
                        end
                    end
                end
                ST_NULL_WAIT: begin
                    // Fourth falling edge after start: take the line, drive null low
                    if (fall) begin
                        next_state = ST_SHIFT_OUT;
                        next_oe_b  = 1'b0;
                        next_dout  = 1'b0;
                        next_slot  = 5'h00;
                        fifo_pop   = fifo_valid;
                        // Straight binary word passes unchanged; no offset or sign
                        next_result = fifo_valid ? fifo_data : '0;
                    end
                end
                ST_SHIFT_OUT: begin
                    // Later input bits are ignored here until select rises
                    if (fall) begin
                        if (slot <= `ADCSO_MSB_LAST) begin
                            next_dout = result[4'(`ADCSO_MSB_LAST - slot)];
                        end else if (!cfg[`ADCSO_ORD_POS] && slot < `ADCSO_TAIL_END) begin
                            // B0 is shared, so the tail starts at B1
                            next_dout = result[4'(slot - `ADCSO_MSB_LAST)];
                        end else begin
                            next_dout = 1'b0;
                        end
                        if (slot == `ADCSO_MSB_LAST) begin
                            next_bias = 1'b0;
                        end
                        if (slot != `ADCSO_TAIL_END) begin
                            next_slot = 5'(slot + 1'b1);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state                <= ST_WAIT_START;
            cfg_cnt              <= 2'h0;
            cfg                  <= 3'h0;
            slot                 <= 5'h00;
            result               <= '0;
            serial_data_out      <= 1'b0;
            serial_data_out_en_b <= 1'b1;
            bias_enable          <= 1'b0;
        end else begin
            state                <= next_state;
            cfg_cnt              <= next_cfg_cnt;
            cfg                  <= next_cfg;
            slot                 <= next_slot;
            result               <= next_result;
            serial_data_out      <= next_dout;
            serial_data_out_en_b <= next_oe_b;
            bias_enable          <= next_bias;
        end
    end

    // Config fields shown straight from the shift register flops
    assign single_or_differential_select = cfg[`ADCSO_SGL_POS];
    assign channel_polarity_select       = cfg[`ADCSO_POL_POS];
    assign byte_order_select             = cfg[`ADCSO_ORD_POS];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    released_idle_a: assert property (!active |=> serial_data_out_en_b)
        else $error("data line driven while select high");
    no_power_idle_a: assert property (!active |=> !bias_enable)
        else $error("bias on while select high");
    ignore_idle_a: assert property (!active |=> state == ST_WAIT_START)
        else $error("sequencer moved while select high");
    take_line_a: assert property (active && state == ST_NULL_WAIT && fall
        |=> !serial_data_out_en_b && !serial_data_out)
        else $error("line not taken low at null bit");
    wait_line_a: assert property (state inside {ST_WAIT_START, ST_CONFIG, ST_NULL_WAIT}
        && !$past(state == ST_NULL_WAIT && fall) |-> serial_data_out_en_b)
        else $error("line driven before null bit");
    msb_first_a: assert property (active && state == ST_SHIFT_OUT && fall
        && slot == 5'h00 |=> serial_data_out == result[11])
        else $error("first result bit not the MSB");
    lsb_tail_a: assert property (active && state == ST_SHIFT_OUT && fall
        && slot == 5'h0c |=> serial_data_out == (!cfg[`ADCSO_ORD_POS] && result[1]))
        else $error("tail bit wrong for byte order");
    zero_fill_a: assert property (active && state == ST_SHIFT_OUT && fall
        && slot == `ADCSO_TAIL_END |=> !serial_data_out)
        else $error("zeros not filled after data");
    auto_off_a: assert property (active && state == ST_SHIFT_OUT && fall
        && slot == `ADCSO_MSB_LAST |=> !bias_enable)
        else $error("no auto shutdown after conversion");
    start_bit_a: assert property (active && state == ST_WAIT_START && rise && !din_s2
        |=> state == ST_WAIT_START)
        else $error("leading zero taken as start");
    three_cfg_a: assert property (active && state == ST_CONFIG && rise
        && cfg_cnt == `ADCSO_CFG_LAST |=> state == ST_NULL_WAIT)
        else $error("config word not three bits");

    cover property (state == ST_SHIFT_OUT && slot == `ADCSO_TAIL_END && !cfg[0]);
    cover property (state == ST_SHIFT_OUT && slot == `ADCSO_TAIL_END && cfg[0]);
    cover property (state == ST_CONFIG ##1 !active);
    cover property (!result_ready);
endmodule : adcso_top

// file: sim/adcso_host.sv
`timescale 1ns/10ps
// Host side of the serial link: select, shift clock and a released-able data pin
module adcso_host (
    input  wire logic sys_clk,  // Bench clock
    input  wire logic wire_in,  // Level on the shared data wire
    output logic      sel_b,    // Select, low = active
    output logic      sclk,     // Shift clock, still outside frames except in noise and its fall just after deselect
    output logic      host_oe,  // High while the host drives the wire
    output logic      host_bit  // Bit the host drives
);
    // Idle: deselected, clock parked low, pin released
    initial begin
        sel_b = 1'b1;
        sclk = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b0;
    end
    // All host pins change just after a rising bench clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // Leading zeros, start bit, config word, then listen; select stays low
    task automatic exchange(input logic [2:0] cfg, input int lead, input int n_out,
                            output logic [27:0] got);
        logic [3:0] word;
        int i;
        word = {1'b1, cfg};
        got = '0;
        sel_b = 1'b0;
        tick(4);
        for (i = 0; i < lead + 4 + n_out; i++) begin
            sclk = 1'b0;                            // Launch on falling edge
            host_oe = (i < lead + 4);               // Let go before 4th fall
            host_bit = (i >= lead && i < lead + 4) ? word[lead + 3 - i] : 1'b0;
            tick(6);
            if (i >= lead + 4) got[i - lead - 4] = wire_in; // Sample before rise
            sclk = 1'b1;
            tick(3);
            if (i == lead + 3) host_oe = 1'b0;      // Off well before 4th fall
            tick(3);
        end
    endtask : exchange
    // Short frames save power, so select goes high as soon as we are done
    task automatic deselect();
        sel_b = 1'b1;
        tick(2);
        sclk = 1'b0;
        tick(4);
    endtask : deselect
    // Clock and data toggling while deselected
    task automatic noise(input int n);
        repeat (n) begin
            sclk = ~sclk;
            host_oe = 1'b1;
            host_bit = 1'($urandom);
            tick(5);
        end
        sclk = 1'b0;
        host_oe = 1'b0;
        tick(2);
    endtask : noise
endmodule : adcso_host

// file: sim/adcso_top_tb.sv
`timescale 1ns/10ps
module adcso_top_tb;
    import adcso_pkg::*;
    logic           sys_clk, rst_b, sel_b, sclk, host_oe, host_bit; // Stimulus
    logic           junk, dout, en_b, result_valid, result_ready;     // Wire and buffer
    logic           bias, sgl, pol, ord;                              // Status outputs
    adcso_word_type result_data;                                      // Converter word
    adcso_word_type model_q[$];                                       // Words in the buffer
    logic [27:0]    got;                                              // Captured result bits
    int             num_errors, n_compared, c;
    wire            data_wire;                                        // Shared data wire
    // Nobody driving: a changing pattern, never a stale level
    assign data_wire = !en_b ? dout : host_oe ? host_bit : junk;
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) junk <= (junk !== 1'b1);
    adcso_top adcso_top_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .select_and_powerdown_input_b(sel_b), .shift_clock(sclk),
        .serial_data_in(data_wire), .serial_data_out(dout), .serial_data_out_en_b(en_b),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
        .bias_enable(bias), .single_or_differential_select(sgl),
        .channel_polarity_select(pol), .byte_order_select(ord));
    adcso_host adcso_host_i (.sys_clk(sys_clk), .wire_in(data_wire), .sel_b(sel_b),
        .sclk(sclk), .host_oe(host_oe), .host_bit(host_bit));
    // Single comparison point
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("Counts: compared=%0d mismatches=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // Offer words back to back while room; a full fill starts with the code extremes,
    // a short fill uses words with the MSB set so they never look like an empty buffer
    task automatic fill(input int n);
        adcso_word_type w;
        int k;
        k = 0;
        while (result_ready === 1'b1 && k < n) begin
            w = (n < 8) ? (12'($urandom) | 12'h800) : (model_q.size() == 0) ? 12'h000
                : (model_q.size() == 1) ? 12'hfff : 12'($urandom);
            result_data = w;
            result_valid = 1'b1;
            adcso_host_i.tick(1);
            model_q.push_back(w);
            k++;
        end
        result_valid = 1'b0;
    endtask : fill
    // One exchange against the reference sequence; empty buffer yields zero
    task automatic run_one(input logic [2:0] cfg, input int n_out);
        adcso_word_type w;
        logic [27:0] e;
        int i;
        adcso_host_i.exchange(cfg, $urandom_range(3), n_out, got);
        w = (model_q.size() > 0) ? model_q.pop_front() : 12'h000;
        e = '0;
        for (i = 0; i < 12; i++) e[1 + i] = w[11 - i];
        if (!cfg[0]) for (i = 0; i < 11; i++) e[13 + i] = w[1 + i];
        if (n_out < 28) e = e & ((28'h1 << n_out) - 28'h1);
        check(got, e);
        check({sgl, pol, ord}, cfg);
        if (n_out == 28) check({en_b, bias}, 2'b00);
        adcso_host_i.deselect();
        check({en_b, bias}, 2'b10);
    endtask : run_one
    initial begin
        void'($urandom(32'h9c5f4416));
        rst_b = 1'b0;
        result_data = '0;
        result_valid = 1'b0;
        num_errors = 0;
        n_compared = 0;
        adcso_host_i.tick(5);
        check({en_b, bias, result_ready, dout}, 4'b1010);
        rst_b = 1'b1;
        adcso_host_i.tick(4);
        $display("test reset done");
        adcso_host_i.noise(20);
        check({en_b, bias, result_ready}, 3'b101);
        $display("test deselected activity done");
        fill(8);
        adcso_host_i.tick(2);
        check({result_ready, 27'(model_q.size())}, 28'h8);
        // A word offered while full must not be taken
        result_data = 12'h5a5;
        result_valid = 1'b1;
        adcso_host_i.tick(3);
        result_valid = 1'b0;
        $display("test buffer fill done");
        for (c = 0; c < 8; c++) begin
            run_one(3'(c), 28);
            if (c == 0) check(result_ready, 1'b1);
        end
        $display("test all codes done");
        // Reset in mid-run: buffer emptied, config bits and line back to rest
        fill(1);
        rst_b = 1'b0;
        adcso_host_i.tick(2);
        check({en_b, bias, result_ready, dout, sgl, pol, ord}, 7'h50);
        rst_b = 1'b1;
        model_q.delete();
        adcso_host_i.tick(4);
        run_one(3'b011, 28);
        $display("test mid-run reset done");
        fill(1);
        run_one(3'b101, 5);
        run_one(3'b010, 28);
        $display("test abort and empty done");
        wrap_up();
    end
    // Eleven exchanges take about 4400 cycles
    initial begin
        #(25 * 30000);
        num_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        wrap_up();
    end
endmodule : adcso_top_tb
